// >>> verilog/xtrig_pkg.sv
// Notes on behaviour
// - Starting a normal trace clears trace-at-execute; analyzer then ignores execute.
// - The execute command sends one pulse on the shared execute line.
// - Execute can be pulsed even with bus interaction turned off.
// - With interaction on, break whenever another enabled unit breaks.
// - With interaction off, ignore the bus execute and ready lines; code still echoes received execute and starts trace at execute.
// - The analyzer always drives line A, as may bus and BNC; the break input always receives it.
// - External analyzer joins line B only in independent state or timing mode.
// - Analyzer trigger asserts its line and is forwarded to receiving ports.
// - Break input may take bus, BNC or analyzer via either line, external analyzer via line B only.
// - Arming from outside uses line B only, analyzer receiving it.
// - With several break sources, break on whichever comes first.
// - Every endpoint link to a line can be switched off on its own, except analyzer and break input on line A.
// - After an analyzer-caused break, the analyzer stops driving that line.
// - Line B breaking and feeding the bus: bus trigger falls after break.
// - Line A breaking, line B feeding bus: bus trigger holds till trace ends.
// - Break input can receive line B, so an external analyzer halts execution.
// - Bus trigger is active low level; BNC trigger is a rising edge.
// - Ready is wire-AND; held low while broken, in reset or not ready.
// - Execute is active low; receiver runs once ready returns true.
// - After execute, bus trigger gives one true pulse, ignored internally.
package xtrig_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] CFG_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] CMD_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h8;

  // Command register bit positions (write one to act)
  localparam int unsigned CMD_TRACE_POS = 0;
  localparam int unsigned CMD_TRACE_EXEC_POS = 1;
  localparam int unsigned CMD_HALT_POS = 2;
  localparam int unsigned CMD_EXEC_POS = 3;

  localparam int unsigned CFG_W = 16;
  localparam int unsigned STAT_W = 8;
  localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;

  // How an endpoint joins an internal line; the fourth code reads as off
  typedef enum logic [1:0] {EP_OFF, EP_DRIVE, EP_RECV} ep_mode_t;

  // Configuration word, bus_a in the low bits
  typedef struct packed {
    logic arm_b;
    logic ext_indep;
    logic run_en;
    logic brk_b;
    ep_mode_t ext_b;
    ep_mode_t ana_b;
    ep_mode_t bnc_b;
    ep_mode_t bus_b;
    ep_mode_t bnc_a;
    ep_mode_t bus_a;
  } cfg_t;

  typedef enum logic {EX_IDLE, EX_WAIT_READY} ex_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic bus_trig_n;
    logic bnc;
    logic ready;
    logic exec_n;
  } pins_in_t;

  typedef struct packed {
    logic bus_trig_o;
    logic bus_trig_oe_n;
    logic bnc_o;
    logic bnc_oe_n;
    logic ready_o;
    logic ready_oe_n;
    logic exec_o;
    logic exec_oe_n;
  } pins_out_t;

  typedef struct packed {
    logic ana_trig;
    logic ext_trig;
    logic broken;
    logic in_reset;
    logic ready_to_run;
  } emu_in_t;

  typedef struct packed {
    logic break_req;
    logic run_req;
    logic ana_arm;
    logic ext_arm;
    logic trace_start;
  } emu_out_t;

endpackage

// >>> verilog/cross_trigger_routing.sv
module cross_trigger_routing
  import xtrig_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire xtrig_pkg::apb_req_t apb_req,
  output xtrig_pkg::apb_rsp_t apb_rsp,
  input wire xtrig_pkg::pins_in_t pins_in,
  output xtrig_pkg::pins_out_t pins_out,
  input wire xtrig_pkg::emu_in_t emu_in,
  output xtrig_pkg::emu_out_t emu_out
);
  import xtrig_pkg::*;

  typedef struct packed {
    cfg_t cfg;
    logic at_exec;
    logic trace_run;
    logic trig_found;
    logic armed;
    logic stop_a;
    logic stop_b;
    logic brk_prev;
    logic bnc_prev;
    logic exec_prev;
    logic mask;
    ex_state_t ex;
    logic break_req;
    logic run_req;
    logic ana_arm;
    logic ext_arm;
    logic trace_start;
    logic bus_drv;
    logic bnc_drv;
    logic rdy_low;
    logic exec_drv;
    logic ack;
    logic err;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and endpoint terms

  logic access;
  logic wr_take;
  logic addr_ok;
  logic cmd_wr;
  logic cfg_wr;
  logic bus_in;
  logic bnc_rise;
  logic exec_fall;
  logic ana_drv_a;
  logic ana_drv_b;
  logic ext_drv_b;
  logic line_a;
  logic line_b;
  logic bus_peer_brk;
  logic brk_rise;
  logic trig_ok;
  logic [STAT_W-1:0] status;
  cfg_t cfg_new;

  // Access phase; write lands only on the edge that sees pready
  assign access = apb_req.psel && apb_req.penable;
  assign wr_take = access && state_ff.ack && apb_req.pwrite && !state_ff.err;
  assign addr_ok = (apb_req.paddr == CFG_OFS) || (apb_req.paddr == CMD_OFS)
                   || (apb_req.paddr == STAT_OFS);
  assign cmd_wr = wr_take && (apb_req.paddr == CMD_OFS);
  assign cfg_wr = wr_take && (apb_req.paddr == CFG_OFS);

  // Bus trigger is low true and level sensed; our own echo is masked
  assign bus_in = !pins_in.bus_trig_n && !state_ff.mask;
  assign bnc_rise = pins_in.bnc && !state_ff.bnc_prev;
  assign exec_fall = !pins_in.exec_n && state_ff.exec_prev;
  assign brk_rise = emu_in.broken && !state_ff.brk_prev;

  // Analyzer is always on line A; it lets go once its break has landed
  assign ana_drv_a = state_ff.trig_found && !state_ff.stop_a;
  assign ana_drv_b = state_ff.trig_found && !state_ff.stop_b
                     && (state_ff.cfg.ana_b == EP_DRIVE);
  // External analyzer is cut off unless it runs standalone
  assign ext_drv_b = state_ff.cfg.ext_indep && (state_ff.cfg.ext_b == EP_DRIVE)
                     && emu_in.ext_trig;

  // Wired OR of every endpoint set to drive; off endpoints add nothing
  assign line_a = ana_drv_a
                  || ((state_ff.cfg.bus_a == EP_DRIVE) && bus_in)
                  || ((state_ff.cfg.bnc_a == EP_DRIVE) && bnc_rise);
  assign line_b = ana_drv_b || ext_drv_b
                  || ((state_ff.cfg.bus_b == EP_DRIVE) && bus_in)
                  || ((state_ff.cfg.bnc_b == EP_DRIVE) && bnc_rise);

  // Another enabled unit pulled ready low: it broke, so we follow
  assign bus_peer_brk = state_ff.cfg.run_en && !pins_in.ready && !emu_in.broken;

  // With external arming the trigger only counts once armed
  assign trig_ok = state_ff.trace_run && (!state_ff.cfg.arm_b || state_ff.armed);

  assign status = {pins_in.ready, state_ff.armed, (state_ff.ex == EX_WAIT_READY),
                   state_ff.at_exec, state_ff.trig_found, state_ff.trace_run,
                   line_b, line_a};

  // Unused mode code 3 is stored as off so the readback matches behaviour
  always_comb
  begin
    cfg_new = cfg_t'(apb_req.pwdata[CFG_W-1:0]);
    if (cfg_new.bus_a == ep_mode_t'(2'h3)) cfg_new.bus_a = EP_OFF;
    if (cfg_new.bnc_a == ep_mode_t'(2'h3)) cfg_new.bnc_a = EP_OFF;
    if (cfg_new.bus_b == ep_mode_t'(2'h3)) cfg_new.bus_b = EP_OFF;
    if (cfg_new.bnc_b == ep_mode_t'(2'h3)) cfg_new.bnc_b = EP_OFF;
    if (cfg_new.ana_b == ep_mode_t'(2'h3)) cfg_new.ana_b = EP_OFF;
    if (cfg_new.ext_b == ep_mode_t'(2'h3)) cfg_new.ext_b = EP_OFF;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.brk_prev = emu_in.broken;
    nxt_state.bnc_prev = pins_in.bnc;
    nxt_state.exec_prev = pins_in.exec_n;
    nxt_state.run_req = 1'b0;
    nxt_state.trace_start = 1'b0;
    nxt_state.exec_drv = 1'b0;

    // One wait state so read data comes from a flop
    nxt_state.ack = access && !state_ff.ack;
    if (access && !state_ff.ack)
    begin
      nxt_state.err = !addr_ok;
      case (apb_req.paddr)
        CFG_OFS: nxt_state.rdata = {{(DATA_W-CFG_W){1'b0}}, state_ff.cfg};
        STAT_OFS: nxt_state.rdata = {{(DATA_W-STAT_W){1'b0}}, status};
        default: nxt_state.rdata = '0;
      endcase
    end
    if (cfg_wr)
      nxt_state.cfg = cfg_new;

    // Analyzer trigger latches and holds until halt or next trace
    if (trig_ok && emu_in.ana_trig)
      nxt_state.trig_found = 1'b1;
    if (state_ff.trace_run && state_ff.cfg.arm_b && line_b
        && (state_ff.cfg.ana_b == EP_RECV))
      nxt_state.armed = 1'b1;

    // Break landed: drop analyzer drive on each line that caused it
    if (brk_rise && ana_drv_a)
      nxt_state.stop_a = 1'b1;
    if (brk_rise && ana_drv_b && state_ff.cfg.brk_b)
      nxt_state.stop_b = 1'b1;

    // Received execute; echo on bus trigger and mask it for one cycle
    nxt_state.mask = exec_fall;
    if (exec_fall)
    begin
      nxt_state.mask = 1'b1;
      if (state_ff.at_exec)
      begin
        nxt_state.at_exec = 1'b0;
        nxt_state.trace_run = 1'b1;
        nxt_state.trig_found = 1'b0;
        nxt_state.armed = 1'b0;
        nxt_state.stop_a = 1'b0;
        nxt_state.stop_b = 1'b0;
        nxt_state.trace_start = 1'b1;
      end
    end

    // Emulator side of execute waits for ready before running
    case (state_ff.ex)
      EX_IDLE:
      begin
        if (exec_fall && state_ff.cfg.run_en)
          nxt_state.ex = EX_WAIT_READY;
      end
      EX_WAIT_READY:
      begin
        if (!state_ff.cfg.run_en)
          nxt_state.ex = EX_IDLE;
        else if (pins_in.ready)
        begin
          nxt_state.ex = EX_IDLE;
          nxt_state.run_req = 1'b1;
        end
      end
      default: nxt_state.ex = EX_IDLE;
    endcase

    // Software commands; the execute pulse ignores run_en entirely
    if (cmd_wr)
    begin
      if (apb_req.pwdata[CMD_TRACE_POS])
      begin
        nxt_state.at_exec = 1'b0;
        nxt_state.trace_run = 1'b1;
        nxt_state.trig_found = 1'b0;
        nxt_state.armed = 1'b0;
        nxt_state.stop_a = 1'b0;
        nxt_state.stop_b = 1'b0;
        nxt_state.trace_start = 1'b1;
      end
      else if (apb_req.pwdata[CMD_TRACE_EXEC_POS])
      begin
        nxt_state.at_exec = 1'b1;
        nxt_state.trace_run = 1'b0;
      end
      if (apb_req.pwdata[CMD_HALT_POS])
      begin
        nxt_state.trace_run = 1'b0;
        nxt_state.trig_found = 1'b0;
        nxt_state.at_exec = 1'b0;
      end
      nxt_state.exec_drv = apb_req.pwdata[CMD_EXEC_POS];
    end

    // Registered pin and emulator outputs
    nxt_state.break_req = line_a || (state_ff.cfg.brk_b && line_b)
                          || bus_peer_brk;
    nxt_state.bus_drv = ((state_ff.cfg.bus_a == EP_RECV) && line_a)
                        || ((state_ff.cfg.bus_b == EP_RECV) && line_b)
                        || exec_fall;
    nxt_state.bnc_drv = ((state_ff.cfg.bnc_a == EP_RECV) && line_a)
                        || ((state_ff.cfg.bnc_b == EP_RECV) && line_b);
    nxt_state.ana_arm = state_ff.cfg.arm_b && (state_ff.cfg.ana_b == EP_RECV)
                        && line_b;
    nxt_state.ext_arm = state_ff.cfg.ext_indep && (state_ff.cfg.ext_b == EP_RECV)
                        && line_b;
    nxt_state.rdy_low = state_ff.cfg.run_en && (emu_in.broken || emu_in.in_reset
                        || !emu_in.ready_to_run);
  end

  // Whole state in one register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= '0;
      state_ff.cfg <= cfg_t'(CFG_RST);
      state_ff.bnc_prev <= 1'b1;
      state_ff.exec_prev <= 1'b1;
      state_ff.ex <= EX_IDLE;
    end
    else
      state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; open-drain pins only ever pull low, BNC drives high

  assign apb_rsp.pready = state_ff.ack;
  assign apb_rsp.pslverr = state_ff.ack && state_ff.err;
  assign apb_rsp.prdata = state_ff.rdata;

  assign pins_out.bus_trig_o = 1'b0;
  assign pins_out.bus_trig_oe_n = !state_ff.bus_drv;
  assign pins_out.bnc_o = 1'b1;
  assign pins_out.bnc_oe_n = !state_ff.bnc_drv;
  assign pins_out.ready_o = 1'b0;
  assign pins_out.ready_oe_n = !state_ff.rdy_low;
  assign pins_out.exec_o = 1'b0;
  assign pins_out.exec_oe_n = !state_ff.exec_drv;

  assign emu_out.break_req = state_ff.break_req;
  assign emu_out.run_req = state_ff.run_req;
  assign emu_out.ana_arm = state_ff.ana_arm;
  assign emu_out.ext_arm = state_ff.ext_arm;
  assign emu_out.trace_start = state_ff.trace_start;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_normal_trace_clear: assert property (
    (cmd_wr && apb_req.pwdata[CMD_TRACE_POS]) |=> (!state_ff.at_exec && state_ff.trace_run))
    else $error("normal trace left trace-at-execute set");

  chk_exec_one_pulse: assert property (
    (cmd_wr && apb_req.pwdata[CMD_EXEC_POS])
    |=> !pins_out.exec_oe_n ##1 pins_out.exec_oe_n)
    else $error("execute command gave no single pulse");

  chk_exec_without_run: assert property (
    (cmd_wr && apb_req.pwdata[CMD_EXEC_POS] && !state_ff.cfg.run_en)
    |=> !pins_out.exec_oe_n)
    else $error("execute not pulsed with interaction off");

  chk_peer_break: assert property (
    bus_peer_brk |=> emu_out.break_req)
    else $error("no break after ready fell");

  chk_off_ignores_bus: assert property (
    (!state_ff.cfg.run_en && !cfg_wr) |=> (!emu_out.run_req && state_ff.ex == EX_IDLE
    && pins_out.ready_oe_n))
    else $error("bus lines acted on with interaction off");

  chk_line_a_breaks: assert property (
    line_a |=> emu_out.break_req)
    else $error("line A did not break");

  // Arm output is registered, so it is judged one cycle after the mode bit
  chk_ext_gated: assert property (
    !state_ff.cfg.ext_indep |-> !ext_drv_b ##1 !emu_out.ext_arm)
    else $error("external analyzer on line B while not standalone");

  chk_bus_forward: assert property (
    (state_ff.cfg.bus_a == EP_RECV && line_a) |=> !pins_out.bus_trig_oe_n)
    else $error("line A not forwarded to bus trigger");

  chk_arm_line_b: assert property (
    emu_out.ana_arm |-> $past(line_b && state_ff.cfg.ana_b == EP_RECV))
    else $error("analyzer armed without line B");

  chk_drop_after_break: assert property (
    (brk_rise && ana_drv_a && !cmd_wr) |=> (!ana_drv_a [*2]))
    else $error("analyzer kept driving after break");

  chk_ready_low_broken: assert property (
    (state_ff.cfg.run_en && emu_in.broken && !cfg_wr) |=> pins_out.ready_oe_n == 1'b0)
    else $error("ready released while broken");

  chk_run_after_ready: assert property (
    (state_ff.ex == EX_WAIT_READY && state_ff.cfg.run_en && pins_in.ready)
    |=> emu_out.run_req ##1 !emu_out.run_req)
    else $error("run not requested on ready");

  chk_echo_masked: assert property (
    exec_fall |=> (!pins_out.bus_trig_oe_n && !bus_in))
    else $error("execute echo missing or not ignored");

  cov_sync_start: cover property (exec_fall ##[1:20] emu_out.run_req);
  cov_peer_break: cover property (bus_peer_brk ##1 emu_out.break_req);
  cov_ext_arm: cover property (state_ff.trace_run && emu_out.ana_arm);
  cov_trig_out: cover property (ana_drv_b ##1 !pins_out.bus_trig_oe_n);

endmodule // cross_trigger_routing

// >>> verif/bus_peers.sv
module bus_peers
  import xtrig_pkg::*;
(
  input wire xtrig_pkg::pins_out_t pins_out,
  input wire logic [3:0] peer,
  output xtrig_pkg::pins_in_t pins_in
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////
  // Other units on the bus: bit 0 trigger, 1 BNC, 2 not ready, 3 execute
  // Pulled-up trigger, any party pulling low wins
  assign pins_in.bus_trig_n = pins_out.bus_trig_oe_n & ~peer[0];
  // BNC sits on a pull-down, so a silent line reads low, never stale
  assign pins_in.bnc = ~pins_out.bnc_oe_n | peer[1];
  // Wire-AND ready: one peer holding low stalls everyone
  assign pins_in.ready = pins_out.ready_oe_n & ~peer[2];
  assign pins_in.exec_n = pins_out.exec_oe_n & ~peer[3];
endmodule // bus_peers

// >>> verif/cross_trigger_routing_tb.sv
module cross_trigger_routing_tb
  import xtrig_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk;
  logic presetn;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  pins_in_t pins_in;
  pins_out_t pins_out;
  emu_in_t emu_in;
  emu_out_t emu_out;
  logic [3:0] peer;
  logic [8:0] obs;
  logic [31:0] seed = 32'h530c;
  logic [31:0] q;
  logic err;
  int num_errors = 0;
  int n_compared = 0;
  int cnt[9];
  int base[9];
  // Expected routing: config, source (0 bus, 1 BNC, 2 ext), watched output, outcome
  int tcfg[9] = '{16'h0004, 16'h1010, 16'h5400, 16'h1400, 16'h0010, 16'h0005, 16'h8210,
    16'h4840, 16'h0000};
  int tk[9] = '{1, 0, 2, 2, 0, 1, 0, 1, 0};
  int tobs[9] = '{5, 5, 5, 5, 5, 5, 7, 8, 5};
  int texp[9] = '{1, 1, 1, 0, 0, 1, 1, 1, 0};

  ////////////////////////////////////////
  cross_trigger_routing u_dut (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .pins_in(pins_in),
    .pins_out(pins_out),
    .emu_in(emu_in),
    .emu_out(emu_out)
  );

  bus_peers u_peers (
    .pins_out(pins_out),
    .peer(peer),
    .pins_in(pins_in)
  );

  // Watched outputs, true when active
  assign obs = {emu_out.ext_arm, emu_out.ana_arm, ~pins_out.ready_oe_n, emu_out.break_req,
    emu_out.trace_start, emu_out.run_req, ~pins_out.bnc_oe_n, ~pins_out.bus_trig_oe_n,
    ~pins_out.exec_oe_n};

  // Tally on the falling edge, well away from the drive edge
  always @(negedge pclk)
  begin
    for (int i = 0; i < 9; i++)
    begin
      cnt[i] += (obs[i] === 1'b1);
    end
  end

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    // No cycle count assumed; a hang is left to the watchdog
    do
    begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    emu_in <= 5'h01;
    peer <= '0;
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
  endtask

  task automatic mark();
    base = cnt;
  endtask

  function automatic int dl(input int i);
    return cnt[i] - base[i];
  endfunction

  task automatic pulse(input int b);
    peer[b] <= 1'b1;
    cyc(1);
    peer[b] <= 1'b0;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Mode code 3 is kept as off
  function automatic logic [31:0] cfg_exp(input logic [15:0] v);
    for (int i = 0; i < 6; i++)
      if (v[2*i +: 2] == 2'd3)
        v[2*i +: 2] = 2'd0;
    return {16'h0, v};
  endfunction

  task automatic tdone(input string s);
    $display("test %s finished, mismatches so far %0d", s, num_errors);
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    apb_req = '0;
    do_reset();
    // Reset value, unmapped access, random config words
    check({28'h0, pins_out.bus_trig_o, pins_out.bnc_o, pins_out.ready_o, pins_out.exec_o},
      32'h4);
    check({28'h0, pins_out.bus_trig_oe_n, pins_out.bnc_oe_n, pins_out.ready_oe_n,
      pins_out.exec_oe_n}, 32'hf);
    apb(1'b0, CFG_OFS, 32'h0);
    check(q, {16'h0, CFG_RST});
    apb(1'b0, 4'hc, 32'h0);
    check(err, 1);
    repeat (4)
    begin
      seed = lfsr(seed);
      wr(CFG_OFS, {16'h0, seed[15:0] | 16'h4000});
      apb(1'b0, CFG_OFS, 32'h0);
      check(q, cfg_exp(seed[15:0] | 16'h4000));
    end
    tdone("registers");
    // Each source alone, reaching break or arm through one line
    for (int i = 0; i < 9; i++)
    begin
      do_reset();
      wr(CFG_OFS, 32'(tcfg[i]));
      mark();
      if (tk[i] == 2)
        emu_in.ext_trig <= 1'b1;
      else
        peer[tk[i]] <= 1'b1;
      cyc(4);
      check(dl(tobs[i]) > 0, texp[i]);
    end
    tdone("routing");
    // Analyzer breaks over line A; line B feeds the bus port, break on B or not
    for (int b = 0; b < 2; b++)
    begin
      do_reset();
      wr(CFG_OFS, 32'h0128 | (b << 12));
      wr(CMD_OFS, 32'h1 << CMD_TRACE_POS);
      mark();
      emu_in.ana_trig <= 1'b1;
      cyc(4);
      check(dl(5) > 0, 1);
      check(pins_out.bnc_oe_n, 0);
      check(pins_out.bus_trig_oe_n, 0);
      emu_in.ana_trig <= 1'b0;
      emu_in.broken <= 1'b1;
      cyc(4);
      check(pins_out.bnc_oe_n, 1);
      check(pins_out.bus_trig_oe_n, b);
      wr(CMD_OFS, 32'h1 << CMD_HALT_POS);
      cyc(2);
      check(pins_out.bus_trig_oe_n, 1);
    end
    tdone("analyzer");
    // Own execute with interaction off; its echo must not break
    do_reset();
    wr(CFG_OFS, 32'h0001);
    mark();
    wr(CMD_OFS, 32'h1 << CMD_EXEC_POS);
    cyc(8);
    check(dl(0), 1);
    check(dl(1), 1);
    check(dl(5), 0);
    check(dl(3), 0);
    tdone("exec_cmd");
    // Received execute waits for the ready wire; a peer not ready forces a break
    do_reset();
    wr(CFG_OFS, 32'h2000);
    peer[2] <= 1'b1;
    mark();
    cyc(1);
    pulse(3);
    cyc(5);
    check(dl(3), 0);
    check(dl(5) > 0, 1);
    peer[2] <= 1'b0;
    cyc(5);
    check(dl(3), 1);
    emu_in.broken <= 1'b1;
    cyc(3);
    check(pins_out.ready_oe_n, 0);
    // Interaction off: ready and execute lines cause no run, no break and no ready drive
    do_reset();
    mark();
    peer[2] <= 1'b1;
    cyc(1);
    pulse(3);
    emu_in.broken <= 1'b1;
    cyc(4);
    check(dl(5), 0);
    check(dl(3), 0);
    check(pins_out.ready_oe_n, 1);
    check(dl(6), 0);
    tdone("exec_rx");
    // Normal trace start cancels a pending trace at execute
    do_reset();
    wr(CMD_OFS, 32'h1 << CMD_TRACE_EXEC_POS);
    apb(1'b0, STAT_OFS, 32'h0);
    check(q[4], 1);
    wr(CMD_OFS, 32'h1 << CMD_TRACE_POS);
    apb(1'b0, STAT_OFS, 32'h0);
    check(q[4], 0);
    mark();
    pulse(3);
    cyc(4);
    check(dl(4), 0);
    wr(CMD_OFS, 32'h1 << CMD_TRACE_EXEC_POS);
    mark();
    pulse(3);
    cyc(4);
    check(dl(4), 1);
    tdone("trace");
    give_verdict();
  end

  // Six short tests, a few hundred cycles in all; far more than enough
  initial
  begin
    #200us;
    num_errors++;
    give_verdict();
  end
endmodule // cross_trigger_routing_tb
